// >>> src/sfqr_regs.svh
// Opcodes, field positions, reset values, timing and host register offsets
`ifndef SFQR_REGS_SVH
`define SFQR_REGS_SVH
`define SFQR_OP_QREAD 8'hEB
`define SFQR_OP_WRITE_ENABLE_CMD 8'h06
`define SFQR_OP_WRAP 8'h77
`define SFQR_OP_PE 8'h81
`define SFQR_OP_SE 8'h20
`define SFQR_OP_HBE 8'h52
`define SFQR_OP_BE 8'hD8
`define SFQR_OP_CE1 8'h60
`define SFQR_OP_CE2 8'hC7
`define SFQR_MEM_BYTES 1048576
`define SFQR_ENH_CODE 2'h2
`define SFQR_WRAP_RST 3'h1
`define SFQR_ADDR_BITS 6'h18
`define SFQR_WRAP_BITS 6'h20
`define SFQR_CLK_PERIOD_NS 8
`define SFQR_ERASE_MIN_NS 1000
`define SFQR_ERASE_MIN_CYC ((`SFQR_ERASE_MIN_NS + `SFQR_CLK_PERIOD_NS - 1) / `SFQR_CLK_PERIOD_NS)
`define SFQR_SCK_PERIOD_NS 80
`define SFQR_SCK_HALF_CYC (`SFQR_SCK_PERIOD_NS / `SFQR_CLK_PERIOD_NS / 2)
`define SFQR_CS_GAP_CYC 4
`define SFQR_REG_CTRL 8'h00
`define SFQR_REG_ADDR 8'h04
`define SFQR_REG_PARAM 8'h08
`define SFQR_REG_STATUS 8'h0C
`define SFQR_REG_RDATA 8'h10
`define SFQR_CTRL_GO 31
`endif

// >>> src/sfqr_pkg.sv
// Types shared by both ends of the serial flash link
package sfqr_pkg;
  typedef enum logic [2:0] {D_IDLE, D_OPC, D_ADDR4, D_MODE, D_DUMMY, D_DATA, D_SER, D_IGNORE}
    sfqr_dstate_e;
  typedef enum logic [2:0] {H_IDLE, H_OPC, H_ADDR4, H_MODE, H_DUMMY, H_DATA, H_SER, H_TAIL}
    sfqr_hphase_e;
  typedef enum logic [1:0] {K_QREAD, K_QSKIP, K_SER, K_RSVD} sfqr_kind_e;
  typedef struct packed {
    logic cs_m, cs_s, cs_d, sck_m, sck_s, sck_d;
    logic [3:0] io_m, io_s;
    sfqr_dstate_e st;
    logic [5:0] cnt;
    logic [31:0] sh;
    logic [7:0] cmd, mode;
    logic [19:0] addr, er_addr;
    logic mode_ok, enh, nib_lo, write_enable_latch, write_in_progress_flag;
    logic [2:0] wrap;
    logic [20:0] er_left;
    logic [15:0] tmr;
    logic [3:0] dq_o, dq_oe;
  } sfqr_dev_s;
  typedef struct packed {
    logic ack, busy, gap, sck, cs_n, armed;
    logic [31:0] dat, addr, sh, rx;
    sfqr_hphase_e st;
    sfqr_kind_e kind;
    logic [7:0] opc, mode, len;
    logic [5:0] nbits;
    logic [8:0] cnt;
    logic [3:0] div, io_m, io_s, dq_o, dq_oe;
  } sfqr_host_s;
endpackage

// >>> src/sfqr_if.sv
// Serial flash link between host controller and device
`timescale 1ns/10ps
`default_nettype none
interface sfqr_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_io_o, h_io_oe, d_io_o, d_io_oe;
  logic [3:0] io;
  // Wire level per line, pulled high when nobody drives
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = h_io_oe[i] ? h_io_o[i] : (d_io_oe[i] ? d_io_o[i] : 1'b1);
    end
  end
  modport host (output cs_n, output sclk, output h_io_o, output h_io_oe, input io);
  modport dev (input cs_n, input sclk, input io, output d_io_o, output d_io_oe);
endinterface
`default_nettype wire

// >>> src/sfqr_dev.sv
// Serial flash device end: quad read, burst wrap, write enable and erase commands
`timescale 1ns/10ps
`default_nettype none
`include "sfqr_regs.svh"
// Summary of operation
// (RL1) Host sets quad enable before quad reads
// (RL2) Address sampled on rise, data on fall
// (RL3) Read address increments, rolls over to zero
// (RL4) Opcode, quad address, two plus four dummies, data
// (RL5) Mode byte after address, then four dummies
// (RL6) Mode bits one-zero keep opcode skipping
// (RL7) Other mode bits leave skipping at reselect
// (RL8) Host may reset mode bits beforehand
// (RL9) Quad read rejected while internal cycle runs
// (RL10) Wrap frame: opcode, 24 dummies, wrap byte
// (RL11) Wrap bits select 8-64 bytes or none
// (RL12) Wrap applies to all later quad reads
// (RL13) Host sets write enable before erasing
// (RL14) Page erase: opcode, page bytes, dummy byte
// (RL15) Sector erase uses address bits twelve and above
// (RL16) Erase frame must end on byte boundary
// (RL17) Erase self-timed; busy flag; latch cleared
// (RL18) Half and full block erase opcodes
// (RL19) Protected half block kept, latch cleared
// (RL20) Protected sector or block not erased
// (RL21) Chip erase only with no protection
// (RL22) Erase frames use line zero only
// (RL23) Write enable command sets the latch
module sfqr_dev (
  input wire logic clk_i,
  input wire logic rst_i,
  sfqr_if.dev link,
  input wire logic quad_enable_bit_i,
  input wire logic [4:0] block_protect_bits_i,
  output logic write_in_progress_flag_o,
  output logic write_enable_latch_o,
  output logic enhanced_mode_o
);
  sfqr_pkg::sfqr_dev_s r_reg, r_next;
  logic [7:0] mem [0:`SFQR_MEM_BYTES-1];
  logic mem_we;
  logic [7:0] mem_q;
  logic cs_rise, cs_fall, sck_rise, sck_fall, quad_ok, prot;
  logic [7:0] opc_byte, wrap_len;
  logic [19:0] inc_addr, next_addr, wrap_mask, er_base;
  logic [20:0] er_len;
  logic [4:0] blk_idx;
  logic [5:0] need_bits;

  // Power-up array pattern: each byte holds its low address bits
  initial begin
    for (int i = 0; i < `SFQR_MEM_BYTES; i++) begin
      mem[i] = i[7:0];
    end
  end

  // Array write port used by the erase walk
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[r_reg.er_addr] <= 8'hFF;
    end
  end
  assign mem_q = mem[r_reg.addr];

  // Edges of the synchronised link signals
  assign cs_fall = r_reg.cs_d & ~r_reg.cs_s;
  assign cs_rise = ~r_reg.cs_d & r_reg.cs_s;
  assign sck_rise = ~r_reg.sck_d & r_reg.sck_s & ~r_reg.cs_s;
  assign sck_fall = r_reg.sck_d & ~r_reg.sck_s & ~r_reg.cs_s;
  assign quad_ok = quad_enable_bit_i & ~r_reg.write_in_progress_flag; // RL1 RL9
  assign opc_byte = {r_reg.sh[6:0], r_reg.io_s[0]};

  // Next read address, linear or inside the wrap section
  assign wrap_len = 8'h08 << r_reg.wrap[2:1]; // RL11
  assign wrap_mask = {12'h000, wrap_len - 8'h01};
  assign inc_addr = r_reg.addr + 20'h0_0001; // RL3
  assign next_addr = r_reg.wrap[0] ? inc_addr :
    ((r_reg.addr & ~wrap_mask) | (inc_addr & wrap_mask)); // RL12

  // Erase region, length, frame length and protection check
  always_comb begin
    er_base = 20'h0_0000;
    er_len = 21'h10_0000;
    need_bits = `SFQR_ADDR_BITS; // RL16
    case (r_reg.cmd)
      `SFQR_OP_PE: begin
        er_base = {r_reg.sh[19:8], 8'h00}; // RL14
        er_len = 21'h00_0100;
      end
      `SFQR_OP_SE: begin
        er_base = {r_reg.sh[19:12], 12'h000}; // RL15
        er_len = 21'h00_1000;
      end
      `SFQR_OP_HBE: begin
        er_base = {r_reg.sh[19:15], 15'h0000}; // RL18
        er_len = 21'h00_8000;
      end
      `SFQR_OP_BE: begin
        er_base = {r_reg.sh[19:16], 16'h0000}; // RL18
        er_len = 21'h01_0000;
      end
      default: begin
        need_bits = 6'h00;
      end
    endcase
  end
  assign blk_idx = {1'b0, er_base[19:16]};
  assign prot = (r_reg.cmd == `SFQR_OP_CE1 || r_reg.cmd == `SFQR_OP_CE2) ?
    (|block_protect_bits_i) : // RL21
    (block_protect_bits_i[4] | ((|block_protect_bits_i[3:0]) &&
    (blk_idx >= 5'h10 - {1'b0, block_protect_bits_i[3:0]}))); // RL19 RL20

  // Frame decoding, read datapath and erase engine
  always_comb begin
    r_next = r_reg;
    mem_we = 1'b0;
    r_next.cs_m = link.cs_n;
    r_next.cs_s = r_reg.cs_m;
    r_next.cs_d = r_reg.cs_s;
    r_next.sck_m = link.sclk;
    r_next.sck_s = r_reg.sck_m;
    r_next.sck_d = r_reg.sck_s;
    r_next.io_m = link.io;
    r_next.io_s = r_reg.io_m;
    // Self-timed erase: one byte per clock, at least the minimum time
    if (r_reg.er_left != 21'h00_0000) begin
      mem_we = 1'b1;
      r_next.er_addr = r_reg.er_addr + 20'h0_0001;
      r_next.er_left = r_reg.er_left - 21'h00_0001;
    end
    if (r_reg.tmr != 16'h0000) begin
      r_next.tmr = r_reg.tmr - 16'h0001;
    end
    if (r_reg.write_in_progress_flag && r_reg.er_left == 21'h00_0000 && r_reg.tmr == 16'h0000) begin
      r_next.write_in_progress_flag = 1'b0; // RL17
      r_next.write_enable_latch = 1'b0; // RL17 RL19
    end
    if (cs_fall) begin
      r_next.cnt = 6'h00;
      r_next.sh = 32'h0000_0000;
      r_next.mode_ok = 1'b0;
      if (r_reg.enh) begin
        r_next.st = quad_ok ? sfqr_pkg::D_ADDR4 : sfqr_pkg::D_IGNORE; // RL6
      end else begin
        r_next.st = sfqr_pkg::D_OPC; // RL7
      end
    end else if (cs_rise) begin
      r_next.st = sfqr_pkg::D_IDLE;
      r_next.dq_oe = 4'h0;
      if (r_reg.mode_ok) begin
        r_next.enh = (r_reg.mode[5:4] == `SFQR_ENH_CODE); // RL6 RL7
      end
      if (r_reg.st == sfqr_pkg::D_SER && !r_reg.write_in_progress_flag) begin
        case (r_reg.cmd)
          `SFQR_OP_WRITE_ENABLE_CMD: begin
            if (r_reg.cnt == 6'h00) begin
              r_next.write_enable_latch = 1'b1; // RL23
            end
          end
          `SFQR_OP_WRAP: begin
            if (r_reg.cnt == `SFQR_WRAP_BITS) begin
              r_next.wrap = r_reg.sh[6:4]; // RL10 RL11
            end
          end
          default: begin
            if (r_reg.write_enable_latch && r_reg.cnt == need_bits) begin // RL13 RL16
              r_next.write_in_progress_flag = 1'b1; // RL17
              r_next.tmr = 16'(`SFQR_ERASE_MIN_CYC);
              r_next.er_addr = er_base;
              r_next.er_left = prot ? 21'h00_0000 : er_len; // RL19 RL20 RL21
            end
          end
        endcase
      end
    end else if (sck_rise) begin
      case (r_reg.st)
        sfqr_pkg::D_OPC: begin
          r_next.sh = {r_reg.sh[30:0], r_reg.io_s[0]};
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == 6'h07) begin
            r_next.cnt = 6'h00;
            r_next.sh = 32'h0000_0000;
            r_next.cmd = opc_byte;
            case (opc_byte)
              `SFQR_OP_QREAD: begin
                r_next.st = quad_ok ? sfqr_pkg::D_ADDR4 : sfqr_pkg::D_IGNORE; // RL1 RL9
              end
              `SFQR_OP_WRITE_ENABLE_CMD, `SFQR_OP_WRAP, `SFQR_OP_PE, `SFQR_OP_SE, `SFQR_OP_HBE,
              `SFQR_OP_BE, `SFQR_OP_CE1, `SFQR_OP_CE2: begin
                r_next.st = r_reg.write_in_progress_flag ? sfqr_pkg::D_IGNORE : sfqr_pkg::D_SER;
              end
              default: begin
                r_next.st = sfqr_pkg::D_IGNORE;
              end
            endcase
          end
        end
        sfqr_pkg::D_ADDR4: begin
          r_next.sh = {r_reg.sh[27:0], r_reg.io_s}; // RL2 RL4
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == 6'h05) begin
            r_next.addr = {r_reg.sh[15:0], r_reg.io_s};
            r_next.cnt = 6'h00;
            r_next.st = sfqr_pkg::D_MODE;
          end
        end
        sfqr_pkg::D_MODE: begin
          r_next.mode = {r_reg.mode[3:0], r_reg.io_s}; // RL5
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == 6'h01) begin
            r_next.mode_ok = 1'b1;
            r_next.cnt = 6'h00;
            r_next.st = sfqr_pkg::D_DUMMY;
          end
        end
        sfqr_pkg::D_DUMMY: begin
          r_next.cnt = r_reg.cnt + 6'h01;
          if (r_reg.cnt == 6'h03) begin
            r_next.nib_lo = 1'b0;
            r_next.st = sfqr_pkg::D_DATA; // RL4 RL5
          end
        end
        sfqr_pkg::D_SER: begin
          r_next.sh = {r_reg.sh[30:0], r_reg.io_s[0]}; // RL22
          if (r_reg.cnt != 6'h3F) begin
            r_next.cnt = r_reg.cnt + 6'h01;
          end
        end
        default: begin
        end
      endcase
    end else if (sck_fall && r_reg.st == sfqr_pkg::D_DATA) begin
      r_next.dq_oe = 4'hF;
      r_next.dq_o = r_reg.nib_lo ? mem_q[3:0] : mem_q[7:4]; // RL2
      r_next.nib_lo = ~r_reg.nib_lo;
      if (r_reg.nib_lo) begin
        r_next.addr = next_addr; // RL3 RL12
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.cs_m <= 1'b1;
      r_reg.cs_s <= 1'b1;
      r_reg.cs_d <= 1'b1;
      r_reg.wrap <= `SFQR_WRAP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign link.d_io_o = r_reg.dq_o;
  assign link.d_io_oe = r_reg.dq_oe;
  assign write_in_progress_flag_o = r_reg.write_in_progress_flag;
  assign write_enable_latch_o = r_reg.write_enable_latch;
  assign enhanced_mode_o = r_reg.enh;
endmodule
`default_nettype wire

// >>> src/sfqr_host.sv
// Host serial flash controller with a classic Wishbone register port
`timescale 1ns/10ps
`default_nettype none
`include "sfqr_regs.svh"
module sfqr_host (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  sfqr_if.host link
);
  sfqr_pkg::sfqr_host_s r_reg, r_next;
  logic req, tick;
  logic [31:0] wmask;

  // Line drive for the phase that the next clock carries
  function automatic logic [7:0] drive(sfqr_pkg::sfqr_hphase_e st, logic [31:0] sh);
    case (st)
      sfqr_pkg::H_OPC, sfqr_pkg::H_SER: drive = {4'h1, 3'h0, sh[31]}; // RL22
      sfqr_pkg::H_ADDR4, sfqr_pkg::H_MODE: drive = {4'hF, sh[31:28]}; // RL4 RL5
      default: drive = 8'h00;
    endcase
  endfunction

  assign req = wb_cyc_i & wb_stb_i;
  assign tick = (r_reg.div == 4'(`SFQR_SCK_HALF_CYC - 1));
  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Register port and frame sequencer
  always_comb begin
    r_next = r_reg;
    r_next.io_m = link.io;
    r_next.io_s = r_reg.io_m;
    r_next.ack = req & ~r_reg.ack;
    if (req && !r_reg.ack) begin
      case (wb_adr_i)
        `SFQR_REG_CTRL: r_next.dat = {r_reg.busy, 21'h00_0000, r_reg.kind, r_reg.opc};
        `SFQR_REG_ADDR: r_next.dat = r_reg.addr;
        `SFQR_REG_PARAM: r_next.dat = {10'h000, r_reg.nbits, r_reg.len, r_reg.mode};
        `SFQR_REG_STATUS: r_next.dat = {31'h0000_0000, r_reg.busy};
        `SFQR_REG_RDATA: r_next.dat = r_reg.rx;
        default: r_next.dat = 32'h0000_0000;
      endcase
    end
    // Writes take effect at the edge where ack is seen high
    if (req && r_reg.ack && wb_we_i && !r_reg.busy) begin
      case (wb_adr_i)
        `SFQR_REG_CTRL: begin
          r_next.opc = (r_reg.opc & ~wmask[7:0]) | (wb_dat_i[7:0] & wmask[7:0]);
          if (wb_sel_i[1]) begin
            r_next.kind = sfqr_pkg::sfqr_kind_e'(wb_dat_i[9:8]);
          end
          if (wb_sel_i[3] && wb_dat_i[`SFQR_CTRL_GO]) begin
            r_next.busy = 1'b1;
          end
        end
        `SFQR_REG_ADDR: r_next.addr = (r_reg.addr & ~wmask) | (wb_dat_i & wmask);
        `SFQR_REG_PARAM: begin
          if (wb_sel_i[0]) r_next.mode = wb_dat_i[7:0];
          if (wb_sel_i[1]) r_next.len = wb_dat_i[15:8];
          if (wb_sel_i[2]) r_next.nbits = wb_dat_i[21:16];
        end
        default: begin
        end
      endcase
    end
    // Frame start: select device and present the first clock's bits
    if (r_reg.busy && r_reg.st == sfqr_pkg::H_IDLE && !r_reg.gap) begin
      r_next.cs_n = 1'b0;
      r_next.div = 4'h0;
      r_next.cnt = 9'h000;
      if (r_reg.kind == sfqr_pkg::K_QSKIP) begin
        r_next.st = sfqr_pkg::H_ADDR4; // RL6
        r_next.sh = {r_reg.addr[23:0], 8'h00};
      end else begin
        r_next.st = sfqr_pkg::H_OPC;
        r_next.sh = {r_reg.opc, 24'h00_0000};
      end
      {r_next.dq_oe, r_next.dq_o} = drive(r_next.st, r_next.sh);
    end else if (r_reg.gap) begin
      r_next.cnt = r_reg.cnt + 9'h001;
      if (r_reg.cnt == 9'(`SFQR_CS_GAP_CYC - 1)) begin
        r_next.gap = 1'b0;
        r_next.busy = 1'b0;
      end
    end else if (r_reg.st != sfqr_pkg::H_IDLE) begin
      r_next.div = tick ? 4'h0 : r_reg.div + 4'h1;
      if (tick && !r_reg.sck && r_reg.st == sfqr_pkg::H_TAIL) begin
        r_next.cs_n = 1'b1; // RL16
        r_next.dq_oe = 4'h0;
        r_next.st = sfqr_pkg::H_IDLE;
        r_next.gap = 1'b1;
        r_next.cnt = 9'h000;
      end else if (tick && !r_reg.sck) begin
        r_next.sck = 1'b1;
        r_next.cnt = r_reg.cnt + 9'h001;
        case (r_reg.st)
          sfqr_pkg::H_OPC: begin
            r_next.sh = {r_reg.sh[30:0], 1'b0};
            if (r_reg.cnt == 9'h007) begin
              r_next.cnt = 9'h000;
              if (r_reg.kind == sfqr_pkg::K_SER) begin
                r_next.sh = r_reg.addr;
                r_next.st = (r_reg.nbits == 6'h00) ? sfqr_pkg::H_TAIL : sfqr_pkg::H_SER;
              end else begin
                r_next.sh = {r_reg.addr[23:0], 8'h00};
                r_next.st = sfqr_pkg::H_ADDR4;
              end
            end
          end
          sfqr_pkg::H_ADDR4: begin
            r_next.sh = {r_reg.sh[27:0], 4'h0};
            if (r_reg.cnt == 9'h005) begin
              r_next.cnt = 9'h000;
              r_next.sh = {r_reg.mode, 24'h00_0000};
              r_next.st = sfqr_pkg::H_MODE;
            end
          end
          sfqr_pkg::H_MODE: begin
            r_next.sh = {r_reg.sh[27:0], 4'h0};
            if (r_reg.cnt == 9'h001) begin
              r_next.cnt = 9'h000;
              r_next.st = sfqr_pkg::H_DUMMY;
            end
          end
          sfqr_pkg::H_DUMMY: begin
            if (r_reg.cnt == 9'h003) begin
              r_next.cnt = 9'h000;
              r_next.armed = 1'b0;
              r_next.st = (r_reg.len == 8'h00) ? sfqr_pkg::H_TAIL : sfqr_pkg::H_DATA;
            end
          end
          sfqr_pkg::H_DATA: begin
            r_next.cnt = r_reg.cnt;
            r_next.armed = 1'b1;
          end
          sfqr_pkg::H_SER: begin
            r_next.sh = {r_reg.sh[30:0], 1'b0};
            if (r_reg.cnt == {3'h0, r_reg.nbits - 6'h01}) begin
              r_next.st = sfqr_pkg::H_TAIL;
            end
          end
          default: begin
          end
        endcase
      end else if (tick) begin
        // Falling edge: sample read data late, then drive the next bits
        r_next.sck = 1'b0;
        {r_next.dq_oe, r_next.dq_o} = drive(r_reg.st, r_reg.sh); // RL2
        if (r_reg.st == sfqr_pkg::H_DATA && r_reg.armed) begin
          r_next.rx = {r_reg.rx[27:0], r_reg.io_s};
          r_next.armed = 1'b0;
          r_next.cnt = r_reg.cnt + 9'h001;
          if (r_reg.cnt == {r_reg.len, 1'b0} - 9'h001) begin
            r_next.st = sfqr_pkg::H_TAIL; // RL4
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '0;
      r_reg.cs_n <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign link.cs_n = r_reg.cs_n;
  assign link.sclk = r_reg.sck;
  assign link.h_io_o = r_reg.dq_o;
  assign link.h_io_oe = r_reg.dq_oe;
endmodule
`default_nettype wire

// >>> sim/sfqr_chk.sv
// Concurrent checks on the serial flash link and device flags
`timescale 1ns/10ps
`default_nettype none
`include "sfqr_regs.svh"
module sfqr_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_io_oe,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe,
  input wire logic write_in_progress_flag_o,
  input wire logic write_enable_latch_o
);
  localparam int MIN_BUSY = `SFQR_ERASE_MIN_CYC - 1;
  logic [20:0] busy_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Length of the current busy stretch
  always_ff @(posedge clk_i) begin
    if (rst_i || !write_in_progress_flag_o) begin
      busy_cnt <= 21'h0;
    end else begin
      busy_cnt <= busy_cnt + 21'h1;
    end
  end
  // Link ownership and drive timing
  a_no_line_clash: assert property ((h_io_oe & d_io_oe) == 4'h0)
    else $error("host and device drive one line");
  a_quad_all_lines: assert property (d_io_oe != 4'h0 |-> d_io_oe == 4'hF)
    else $error("read data not on all four lines");
  a_release_deselect: assert property (cs_n [*8] |-> d_io_oe == 4'h0)
    else $error("device drives while deselected");
  a_busy_no_drive: assert property (write_in_progress_flag_o |-> d_io_oe == 4'h0)
    else $error("read answered during internal cycle");
  a_data_on_fall: assert property ($changed(d_io_o) && d_io_oe == 4'hF |-> !sclk)
    else $error("read data changed while clock high");
  // Self-timed cycle and latch
  a_latch_drop_done: assert property ($fell(write_in_progress_flag_o) |-> !write_enable_latch_o)
    else $error("latch kept after cycle end");
  a_busy_min_len: assert property ($fell(write_in_progress_flag_o) |-> busy_cnt >= MIN_BUSY)
    else $error("internal cycle too short");
  a_busy_after_cs: assert property ($rose(write_in_progress_flag_o) |-> cs_n && $past(cs_n, 2))
    else $error("cycle started inside a frame");
  a_latch_set_idle: assert property ($rose(write_enable_latch_o) |-> cs_n && !write_in_progress_flag_o)
    else $error("latch set at wrong time");
  c_erase: cover property ($rose(write_in_progress_flag_o));
  c_read: cover property ($rose(d_io_oe[0]));
  c_latch: cover property ($fell(write_enable_latch_o));
endmodule
`default_nettype wire

// >>> sim/sfqr_tb.sv
// Self-checking bench for the serial flash host and device pair
`timescale 1ns/10ps
`default_nettype none
`include "sfqr_regs.svh"
module sfqr_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic qe = 1'b0;
  logic [4:0] bp = 5'h00;
  logic write_in_progress_flag;
  logic write_enable_latch;
  logic enh;
  logic [31:0] rd;
  logic [7:0] len;
  int miscompares = 0;
  int n_checks = 0;
  sfqr_if bus ();
  // Clock and the two ends
  always #4 clk_i = ~clk_i;
  sfqr_host sfqr_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(bus));
  sfqr_dev sfqr_dev_i (.clk_i(clk_i), .rst_i(rst_i), .link(bus), .quad_enable_bit_i(qe),
    .block_protect_bits_i(bp), .write_in_progress_flag_o(write_in_progress_flag),
    .write_enable_latch_o(write_enable_latch), .enhanced_mode_o(enh));
  sfqr_chk sfqr_chk_i (.clk_i(clk_i), .rst_i(rst_i), .cs_n(bus.cs_n), .sclk(bus.sclk),
    .h_io_oe(bus.h_io_oe), .d_io_o(bus.d_io_o), .d_io_oe(bus.d_io_oe),
    .write_in_progress_flag_o(write_in_progress_flag), .write_enable_latch_o(write_enable_latch));
  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic lapse();
    miscompares++;
    $display("mismatch at %0t: wait ran out", $time);
    complete_run();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle, read data left in rd
  // Ack is looked at mid-cycle, then the request is held through the ack edge
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= dat;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 64);
    if (n == 64) lapse();
    rd = wb_rdat;
    @(posedge clk_i);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // Start one link frame and wait for the host to finish it
  task automatic op(input logic [7:0] opc, input logic [1:0] kind, input logic [31:0] adr,
                    input logic [5:0] nb, input logic [7:0] mode);
    int n;
    wb(1'b1, `SFQR_REG_ADDR, adr);
    wb(1'b1, `SFQR_REG_PARAM, {10'h000, nb, 8'h04, mode});
    wb(1'b1, `SFQR_REG_CTRL, {1'b1, 21'h0, kind, opc});
    n = 0;
    do begin
      wb(1'b0, `SFQR_REG_STATUS, 32'h0000_0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 4000);
    if (n == 4000) lapse();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic ser(input logic [7:0] opc, input logic [31:0] adr, input logic [5:0] nb);
    op(opc, sfqr_pkg::K_SER, adr, nb, 8'h00);
  endtask
  // Four-byte quad read compared against the expected bytes
  task automatic qr(input logic [23:0] a, input logic [7:0] mode, input logic [1:0] kind,
                    input logic [31:0] exp);
    op(`SFQR_OP_QREAD, kind, {8'h00, a}, 6'h00, mode);
    wb(1'b0, `SFQR_REG_RDATA, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wait_dev();
    int n;
    n = 0;
    while (write_in_progress_flag === 1'b1 && n < 70000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 70000) lapse();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic erase(input logic [7:0] opc, input logic [31:0] adr, input logic [5:0] nb);
    ser(`SFQR_OP_WRITE_ENABLE_CMD, 32'h0000_0000, 6'h00);
    ser(opc, adr, nb);
    wait_dev();
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk({29'h0, write_in_progress_flag, write_enable_latch, enh}, 32'h0000_0000);
    wb(1'b0, 8'h20, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    qr(24'h00_0010, 8'h00, sfqr_pkg::K_QREAD, 32'hFFFF_FFFF);
    qe <= 1'b1;
    qr(24'h0F_FFFE, 8'h00, sfqr_pkg::K_QREAD, 32'hFEFF_0001);
    qr(24'h00_0123, 8'h20, sfqr_pkg::K_QREAD, 32'h2324_2526);
    chk({31'h0, enh}, 32'h0000_0001);
    qr(24'h00_0200, 8'h00, sfqr_pkg::K_QSKIP, 32'h0001_0203);
    chk({31'h0, enh}, 32'h0000_0000);
    // Every wrap length, read across the section end
    for (int i = 0; i < 4; i++) begin
      ser(`SFQR_OP_WRAP, {24'h0, 1'b0, i[1:0], 5'h00}, 6'h20);
      len = 8'h08 << i;
      qr({16'h0003, len - 8'h02}, 8'h00, sfqr_pkg::K_QREAD, {len - 8'h02, len - 8'h01, 16'h0001});
    end
    ser(`SFQR_OP_WRAP, 32'h0000_0010, 6'h20);
    qr(24'h00_03FE, 8'h00, sfqr_pkg::K_QREAD, 32'hFEFF_0001);
    // Erase refusals and sector erase
    ser(`SFQR_OP_SE, 32'h0012_3400, 6'h18);
    chk({31'h0, write_in_progress_flag}, 32'h0000_0000);
    ser(`SFQR_OP_WRITE_ENABLE_CMD, 32'h0000_0000, 6'h00);
    chk({31'h0, write_enable_latch}, 32'h0000_0001);
    ser(`SFQR_OP_SE, 32'h0012_3400, 6'h17);
    chk({30'h0, write_in_progress_flag, write_enable_latch}, 32'h0000_0001);
    ser(`SFQR_OP_SE, 32'h0012_3400, 6'h18);
    chk({31'h0, write_in_progress_flag}, 32'h0000_0001);
    qr(24'h00_0010, 8'h00, sfqr_pkg::K_QREAD, 32'hFFFF_FFFF);
    chk({31'h0, write_in_progress_flag}, 32'h0000_0001);
    wait_dev();
    chk({31'h0, write_enable_latch}, 32'h0000_0000);
    qr(24'h00_0FFE, 8'h00, sfqr_pkg::K_QREAD, 32'hFEFF_FFFF);
    qr(24'h00_1FFE, 8'h00, sfqr_pkg::K_QREAD, 32'hFFFF_0001);
    erase(`SFQR_OP_PE, 32'h0023_0000, 6'h18);
    qr(24'h00_23FE, 8'h00, sfqr_pkg::K_QREAD, 32'hFFFF_0001);
    qr(24'h00_22FE, 8'h00, sfqr_pkg::K_QREAD, 32'hFEFF_FFFF);
    // Protected regions keep their contents
    bp <= 5'h01;
    erase(`SFQR_OP_HBE, 32'h0F80_0000, 6'h18);
    chk({31'h0, write_enable_latch}, 32'h0000_0000);
    qr(24'h0F_8000, 8'h00, sfqr_pkg::K_QREAD, 32'h0001_0203);
    erase(`SFQR_OP_BE, 32'h0F00_0000, 6'h18);
    qr(24'h0F_0000, 8'h00, sfqr_pkg::K_QREAD, 32'h0001_0203);
    erase(`SFQR_OP_CE1, 32'h0000_0000, 6'h00);
    erase(`SFQR_OP_CE2, 32'h0000_0000, 6'h00);
    qr(24'h00_0000, 8'h00, sfqr_pkg::K_QREAD, 32'h0001_0203);
    bp <= 5'h00;
    erase(`SFQR_OP_BE, 32'h0E12_3400, 6'h18);
    qr(24'h0D_FFFE, 8'h00, sfqr_pkg::K_QREAD, 32'hFEFF_FFFF);
    qr(24'h0E_FFFE, 8'h00, sfqr_pkg::K_QREAD, 32'hFFFF_0001);
    complete_run();
  end
endmodule
`default_nettype wire
